// >>> src/haptic_front_end.sv
// Haptic front end: registers, trigger, sequencer and drive select
`default_nettype none
// How it works
// - duty times clamp for rotating mass
// - mode field picks the input interface
// - PWM mode drives from pin continuously
// - resonant PWM open loop divides by 128
// - seven libraries, library six is resonant
// - launch starts playback at slot zero
// - advance on nonzero slot, stop after eight
// - MSB clear means waveform identifier 1-127
// - MSB set means wait of 10 ms units
// - offsets only touch library waveforms
// - signed offsets lengthen or shorten segments
// - peak level overdrive, lowest level brake
// - ramps interpolate over adjusted duration
// - step 5 ms, or 1 ms when fine
// - realtime register value drives amplitude
// - open-loop period sets resonant drive rate in analog and realtime modes
// - analog code maps linearly to drive
// - continuous modes run while mode held
// - trigger pin may control launch bit
// - host sets launch, clearing it cancels
// - edge mode rising toggles, falling ignored
// - level mode launch follows pin level
module haptic_front_end #(
	parameter int MS_CYC = haptic_pkg::MS_CYCLES,
	parameter int OL_HALF_CYC = haptic_pkg::OL_HALF_CYCLES,
	parameter logic [6:0] BUS_ADDR = 7'h2c
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic trig_pin,
	input wire logic [7:0] analog_code,
	output logic [14:0] rom_addr,
	input wire haptic_pkg::rom_word_t rom_data,
	output logic signed [8:0] drive_level,
	output logic drive_active,
	output logic track_resonance,
	output logic drive_polarity,
	output logic [2:0] active_mode
);
	typedef enum {S_IDLE, S_SLOT, S_SCAN, S_SEG, S_RUN, S_WAIT} seq_t;
	localparam int HALF_EDGES = haptic_pkg::PWM_DIV_EDGES / 2;

	function automatic logic in_range(input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		in_range = a >= lo && a <= hi;
	endfunction

	haptic_pkg::reg_wr_t wr;
	logic [7:0] rd_ptr, rd_data;
	logic [7:0] mode_q, realtime_q, lib_q, clamp_q;
	logic [7:0] fbctl_q, ctrl3_q, ctrl5_q, olp_q;
	logic [7:0] slot_q [8];
	logic [7:0] ofs_q [4];
	logic go_q;
	logic [1:0] pin_s_q;
	logic pin_q;
	seq_t st_q;
	logic [2:0] slot_ix_q;
	logic signed [7:0] max_q, min_q, start_q, tgt_q, seq_lvl_q;
	logic ramp_q, last_q, dir_q;
	logic [8:0] len_q, el_q, mag_q, q_q;
	logic [9:0] rem_q;
	logic [10:0] wait_q;
	logic [17:0] ms_q;
	logic [2:0] step_q;
	logic [3:0] samp_q;
	logic [7:0] win_q, duty_q;
	logic [8:0] hi_q;
	logic [5:0] edge_q;
	logic pwm_pol_q, per_pol_q;
	logic [13:0] ol_q;
	logic [6:0] unit_q;

	assign sda_out = 1'b0;

	i2c_reg_port #(.BUS_ADDR(BUS_ADDR)) u_port (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.rd_addr(rd_ptr),
		.rd_data(rd_data),
		.wr(wr)
	);

	// Mode and control decode
	wire [2:0] mode = mode_q[2:0];
	wire stby = mode_q[haptic_pkg::STBY_BIT];
	wire resonant = fbctl_q[haptic_pkg::RES_BIT];
	wire ol_sel = ctrl3_q[haptic_pkg::OL_BIT];
	wire rom_mode = mode <= 3'(haptic_pkg::MODE_LEVEL);
	wire pwm_mode = mode == 3'(haptic_pkg::MODE_PWM);
	wire ana_mode = mode == 3'(haptic_pkg::MODE_ANALOG);
	wire rt_mode = mode == 3'(haptic_pkg::MODE_REALTIME);
	wire cont_mode = pwm_mode || ana_mode || rt_mode;
	wire edge_mode = mode == 3'(haptic_pkg::MODE_EDGE);
	wire lvl_mode = mode == 3'(haptic_pkg::MODE_LEVEL);

	// Write decode shared by register file and launch bit
	wire slot_wr = in_range(wr.addr, haptic_pkg::REG_SLOT0,
		haptic_pkg::REG_SLOT7);
	wire ofs_wr = in_range(wr.addr, haptic_pkg::REG_OFS0,
		haptic_pkg::REG_OFS3);
	wire [7:0] slot_wi = wr.addr - haptic_pkg::REG_SLOT0;
	wire [7:0] ofs_wi = wr.addr - haptic_pkg::REG_OFS0;
	wire go_wr = wr.en && wr.addr == haptic_pkg::REG_GO;
	wire pin_rise = pin_s_q[1] && !pin_q;

	// Register file writes
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= haptic_pkg::MODE_RST;
			realtime_q <= 8'h00;
			lib_q <= 8'h00;
			clamp_q <= haptic_pkg::CLAMP_RST;
			fbctl_q <= 8'h00;
			ctrl3_q <= 8'h00;
			ctrl5_q <= 8'h00;
			olp_q <= haptic_pkg::OLP_RST;
			for (int i = 0; i < 8; i++) begin
				slot_q[i] <= 8'h00;
			end
			for (int i = 0; i < 4; i++) begin
				ofs_q[i] <= 8'h00;
			end
		end else if (wr.en) begin
			if (wr.addr == haptic_pkg::REG_MODE) begin
				mode_q <= wr.data;
			end else if (wr.addr == haptic_pkg::REG_REALTIME) begin
				realtime_q <= wr.data;
			end else if (wr.addr == haptic_pkg::REG_LIB) begin
				lib_q <= wr.data;
			end else if (slot_wr) begin
				slot_q[slot_wi[2:0]] <= wr.data;
			end else if (ofs_wr) begin
				ofs_q[ofs_wi[1:0]] <= wr.data;
			end else if (wr.addr == haptic_pkg::REG_CLAMP) begin
				clamp_q <= wr.data;
			end else if (wr.addr == haptic_pkg::REG_FBCTL) begin
				fbctl_q <= wr.data;
			end else if (wr.addr == haptic_pkg::REG_CTRL3) begin
				ctrl3_q <= wr.data;
			end else if (wr.addr == haptic_pkg::REG_CTRL5) begin
				ctrl5_q <= wr.data;
			end else if (wr.addr == haptic_pkg::REG_OLP) begin
				olp_q <= wr.data;
			end
		end
	end

	// Read decode; unmapped offsets read zero
	wire [7:0] slot_ri = rd_ptr - haptic_pkg::REG_SLOT0;
	wire [7:0] ofs_ri = rd_ptr - haptic_pkg::REG_OFS0;
	wire busy = st_q != S_IDLE;
	always_comb begin
		rd_data = 8'h00;
		if (rd_ptr == haptic_pkg::REG_STATUS) begin
			rd_data = {6'h00, go_q, busy};
		end else if (rd_ptr == haptic_pkg::REG_MODE) begin
			rd_data = mode_q;
		end else if (rd_ptr == haptic_pkg::REG_REALTIME) begin
			rd_data = realtime_q;
		end else if (rd_ptr == haptic_pkg::REG_LIB) begin
			rd_data = lib_q;
		end else if (in_range(rd_ptr, haptic_pkg::REG_SLOT0,
			haptic_pkg::REG_SLOT7)) begin
			rd_data = slot_q[slot_ri[2:0]];
		end else if (rd_ptr == haptic_pkg::REG_GO) begin
			rd_data = {7'h00, go_q};
		end else if (in_range(rd_ptr, haptic_pkg::REG_OFS0,
			haptic_pkg::REG_OFS3)) begin
			rd_data = ofs_q[ofs_ri[1:0]];
		end else if (rd_ptr == haptic_pkg::REG_CLAMP) begin
			rd_data = clamp_q;
		end else if (rd_ptr == haptic_pkg::REG_FBCTL) begin
			rd_data = fbctl_q;
		end else if (rd_ptr == haptic_pkg::REG_CTRL3) begin
			rd_data = ctrl3_q;
		end else if (rd_ptr == haptic_pkg::REG_CTRL5) begin
			rd_data = ctrl5_q;
		end else if (rd_ptr == haptic_pkg::REG_OLP) begin
			rd_data = olp_q;
		end
	end

	// Trigger pin synchroniser and edge history
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s_q <= 2'h0;
			pin_q <= 1'b0;
		end else begin
			pin_s_q <= {pin_s_q[0], trig_pin};
			pin_q <= pin_s_q[1];
		end
	end

	// Sequencer decode
	wire [7:0] slot_v = slot_q[slot_ix_q];
	wire [4:0] idx = rom_addr[4:0];
	wire r_last = rom_data.last || idx == 5'h1f;
	wire signed [7:0] r_lvl = rom_data.level;
	wire [1:0] cls = (r_lvl == max_q) ? 2'd0 :
		(r_lvl == min_q) ? 2'd3 :
		(r_lvl > 8'sd0) ? 2'd1 : 2'd2;
	wire [7:0] ofs_v = ofs_q[cls];
	wire signed [9:0] adj = $signed({2'b00, rom_data.dur}) +
		$signed({{2{ofs_v[7]}}, ofs_v});
	wire skip = adj <= 10'sd0;
	wire signed [8:0] diff = {r_lvl[7], r_lvl} -
		{seq_lvl_q[7], seq_lvl_q};
	wire ms_tick = ms_q == 18'(MS_CYC - 1);
	wire [2:0] step_len = ctrl5_q[haptic_pkg::FINE_BIT] ?
		3'(haptic_pkg::FINE_STEP_MS) :
		3'(haptic_pkg::COARSE_STEP_MS);
	wire step_tick = ms_tick && step_q == step_len - 3'd1;
	wire [10:0] wait_len = 11'(slot_v[6:0]) *
		11'(haptic_pkg::WAIT_UNIT_MS);
	wire settle = rem_q >= {1'b0, len_q};
	wire run_end = el_q == len_q && !settle && !step_tick;
	wire seg_end = (st_q == S_RUN && run_end && last_q) ||
		(st_q == S_SEG && skip && r_last);
	wire wait_end = st_q == S_WAIT && wait_q >= wait_len;
	wire slot_adv = seg_end || wait_end;
	wire zero_end = st_q == S_SLOT && slot_v == 8'h00;
	wire finish = zero_end || (slot_adv && slot_ix_q == 3'd7);
	wire abort = !go_q || stby || !rom_mode;
	wire signed [9:0] ramp_v = dir_q ?
		$signed({{2{start_q[7]}}, start_q}) - $signed({1'b0, q_q}) :
		$signed({{2{start_q[7]}}, start_q}) + $signed({1'b0, q_q});

	// Launch bit: pin, host write and end of sequence
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			go_q <= 1'b0;
		end else if (lvl_mode) begin
			go_q <= pin_s_q[1];
		end else if (go_wr) begin
			go_q <= wr.data[0];
		end else if (edge_mode && pin_rise) begin
			go_q <= !go_q;
		end else if (finish || stby) begin
			go_q <= 1'b0;
		end
	end

	// Millisecond divider and playback step counter
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_q <= 18'h0;
			step_q <= 3'h0;
		end else if (st_q == S_IDLE) begin
			ms_q <= 18'h0;
			step_q <= 3'h0;
		end else begin
			ms_q <= ms_tick ? 18'h0 : ms_q + 18'h1;
			if (step_tick) begin
				step_q <= 3'h0;
			end else if (ms_tick) begin
				step_q <= step_q + 3'h1;
			end
		end
	end

	// Waveform sequencer
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= S_IDLE;
			slot_ix_q <= 3'h0;
			rom_addr <= 15'h0;
			{max_q, min_q, start_q, tgt_q, seq_lvl_q} <= '0;
			{ramp_q, last_q, dir_q} <= 3'h0;
			{len_q, el_q, mag_q, q_q} <= '0;
			rem_q <= 10'h0;
			wait_q <= 11'h0;
		end else if (st_q != S_IDLE && (abort || finish)) begin
			st_q <= S_IDLE;
			seq_lvl_q <= 8'sd0;
		end else if (slot_adv) begin
			slot_ix_q <= slot_ix_q + 3'd1;
			st_q <= S_SLOT;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (go_q && rom_mode && !stby) begin
						slot_ix_q <= 3'h0;
						st_q <= S_SLOT;
					end
				end
				S_SLOT: begin
					seq_lvl_q <= 8'sd0;
					wait_q <= 11'h0;
					max_q <= 8'sh80;
					min_q <= 8'sd127;
					// Library and identifier form the entry address
					rom_addr <= {lib_q[2:0], slot_v[6:0], 5'h00};
					st_q <= slot_v[7] ? S_WAIT : S_SCAN;
				end
				S_SCAN: begin
					if (r_lvl > max_q) begin
						max_q <= r_lvl;
					end
					if (r_lvl < min_q) begin
						min_q <= r_lvl;
					end
					rom_addr[4:0] <= r_last ? 5'h00 : idx + 5'h01;
					st_q <= r_last ? S_SEG : S_SCAN;
				end
				S_SEG: begin
					if (skip) begin
						rom_addr[4:0] <= idx + 5'h01;
					end else begin
						len_q <= adj[8:0];
						{el_q, q_q, rem_q} <= '0;
						start_q <= seq_lvl_q;
						tgt_q <= r_lvl;
						ramp_q <= rom_data.ramp;
						last_q <= r_last;
						dir_q <= diff[8];
						// Flat segments skip the division, end on the step
						mag_q <= !rom_data.ramp ? 9'd0 :
							diff[8] ? 9'(-diff) : 9'(diff);
						seq_lvl_q <= rom_data.ramp ? seq_lvl_q : r_lvl;
						st_q <= S_RUN;
					end
				end
				S_RUN: begin
					// Ramp level is start plus diff*elapsed/len
					if (step_tick) begin
						el_q <= el_q + 9'd1;
						rem_q <= rem_q + {1'b0, mag_q};
					end else if (settle) begin
						rem_q <= rem_q - {1'b0, len_q};
						q_q <= q_q + 9'd1;
					end else if (run_end) begin
						rom_addr[4:0] <= idx + 5'h01;
						st_q <= S_SEG;
					end
					seq_lvl_q <= ramp_q ? ramp_v[7:0] : tgt_q;
				end
				S_WAIT: begin
					if (ms_tick) begin
						wait_q <= wait_q + 11'h1;
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// Duty measurement over a window of 256 pin samples
	wire samp_tick = samp_q == 4'(haptic_pkg::DUTY_SAMPLE_CYCLES - 1);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			{samp_q, win_q, hi_q, duty_q} <= '0;
		end else begin
			samp_q <= samp_tick ? 4'h0 : samp_q + 4'h1;
			if (samp_tick) begin
				win_q <= win_q + 8'h01;
				if (win_q == 8'hff) begin
					duty_q <= hi_q[8] ? 8'hff : hi_q[7:0];
					hi_q <= 9'(pin_s_q[1]);
				end else begin
					hi_q <= hi_q + 9'(pin_s_q[1]);
				end
			end
		end
	end

	// Commutation from pin edges and from the open-loop period
	wire ol_unit = ol_q == 14'(OL_HALF_CYC - 1);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_q <= 6'h0;
			{pwm_pol_q, per_pol_q} <= 2'h3;
			ol_q <= 14'h0;
			unit_q <= 7'h0;
		end else begin
			if (pin_rise) begin
				edge_q <= edge_q + 6'h1;
				if (edge_q == 6'(HALF_EDGES - 1)) begin
					pwm_pol_q <= !pwm_pol_q;
				end
			end
			ol_q <= ol_unit ? 14'h0 : ol_q + 14'h1;
			if (ol_unit && olp_q[6:0] != 7'h0) begin
				if (unit_q >= olp_q[6:0] - 7'h1) begin
					unit_q <= 7'h0;
					per_pol_q <= !per_pol_q;
				end else begin
					unit_q <= unit_q + 7'h1;
				end
			end
		end
	end

	// Drive selection for the actuator loop
	wire [15:0] scaled = duty_q * clamp_q;
	wire [7:0] pwm_amp = resonant ? duty_q : scaled[15:8];
	wire [7:0] cont_amp = pwm_mode ? pwm_amp :
		ana_mode ? analog_code : realtime_q;
	wire ol_on = resonant && ol_sel && cont_mode;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_level <= 9'sd0;
			drive_active <= 1'b0;
			track_resonance <= 1'b0;
			drive_polarity <= 1'b1;
			active_mode <= 3'h0;
		end else begin
			active_mode <= mode;
			drive_active <= !stby && (cont_mode || busy);
			track_resonance <= resonant && !ol_on;
			drive_polarity <= !ol_on ? 1'b1 :
				pwm_mode ? pwm_pol_q : per_pol_q;
			if (stby) begin
				drive_level <= 9'sd0;
			end else if (cont_mode) begin
				drive_level <= $signed({1'b0, cont_amp});
			end else begin
				drive_level <= {seq_lvl_q[7], seq_lvl_q};
			end
		end
	end
endmodule
`default_nettype wire

// >>> src/haptic_pkg.sv
// Shared constants and types for the haptic playback front end
`default_nettype none
package haptic_pkg;
	// Clock and time bases
	localparam int CLK_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int COARSE_STEP_MS = 5;
	localparam int FINE_STEP_MS = 1;
	localparam int WAIT_UNIT_MS = 10;
	localparam int OL_UNIT_NS = 98490;
	localparam int OL_HALF_CYCLES = OL_UNIT_NS / (2 * CLK_NS);
	localparam int PWM_DIV_EDGES = 128;
	localparam int DUTY_SAMPLE_CYCLES = 16;
	// Register offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MODE = 8'h01;
	localparam logic [7:0] REG_REALTIME = 8'h02;
	localparam logic [7:0] REG_LIB = 8'h03;
	localparam logic [7:0] REG_SLOT0 = 8'h04;
	localparam logic [7:0] REG_SLOT7 = 8'h0b;
	localparam logic [7:0] REG_GO = 8'h0c;
	localparam logic [7:0] REG_OFS0 = 8'h0d;
	localparam logic [7:0] REG_OFS3 = 8'h10;
	localparam logic [7:0] REG_CLAMP = 8'h17;
	localparam logic [7:0] REG_FBCTL = 8'h1a;
	localparam logic [7:0] REG_CTRL3 = 8'h1d;
	localparam logic [7:0] REG_CTRL5 = 8'h1f;
	localparam logic [7:0] REG_OLP = 8'h20;
	// Field positions and reset values
	localparam int STBY_BIT = 6;
	localparam int RES_BIT = 7;
	localparam int OL_BIT = 0;
	localparam int FINE_BIT = 0;
	localparam logic [7:0] MODE_RST = 8'h40;
	localparam logic [7:0] CLAMP_RST = 8'hff;
	localparam logic [7:0] OLP_RST = 8'h40;
	// Interface modes held in the low bits of the mode register
	typedef enum logic [2:0] {
		MODE_MEM, MODE_EDGE, MODE_LEVEL, MODE_PWM,
		MODE_ANALOG, MODE_REALTIME, MODE_AUDIO, MODE_SPARE
	} mode_t;
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_t;
	typedef struct packed {
		logic last;
		logic ramp;
		logic signed [7:0] level;
		logic [7:0] dur;
	} rom_word_t;
endpackage
`default_nettype wire

// >>> src/i2c_reg_port.sv
// Two-wire serial slave giving byte access to the register file
`default_nettype none
module i2c_reg_port #(
	parameter logic [6:0] BUS_ADDR = 7'h2c
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	output haptic_pkg::reg_wr_t wr
);
	typedef enum {P_IDLE, P_ADDR, P_REG, P_WDATA, P_RDATA} phase_t;
	phase_t phase_q;
	logic [1:0] scl_s_q, sda_s_q;
	logic scl_q, sda_q, ack_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q, tx_q;
	wire scl_rise = scl_s_q[1] & ~scl_q;
	wire scl_fall = ~scl_s_q[1] & scl_q;
	wire start = scl_q & scl_s_q[1] & sda_q & ~sda_s_q[1];
	wire stop = scl_q & scl_s_q[1] & ~sda_q & sda_s_q[1];
	wire addr_hit = shift_q[7:1] == BUS_ADDR;

	// Pin synchronisers and edge history
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_in};
			sda_s_q <= {sda_s_q[0], sda_in};
			scl_q <= scl_s_q[1];
			sda_q <= sda_s_q[1];
		end
	end

	// Byte framing, acknowledge and pointer handling
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= P_IDLE;
			ack_q <= 1'b0;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			sda_oe <= 1'b0;
			rd_addr <= 8'h00;
			wr <= '0;
		end else begin
			wr.en <= 1'b0;
			if (start) begin
				phase_q <= P_ADDR;
				ack_q <= 1'b0;
				cnt_q <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop) begin
				phase_q <= P_IDLE;
				ack_q <= 1'b0;
				sda_oe <= 1'b0;
			end else if (phase_q != P_IDLE && scl_rise) begin
				if (!ack_q) begin
					shift_q <= {shift_q[6:0], sda_s_q[1]};
					cnt_q <= cnt_q + 4'h1;
				end else if (phase_q == P_RDATA && sda_s_q[1]) begin
					phase_q <= P_IDLE; // Master ends the read
				end
			end else if (phase_q != P_IDLE && scl_fall) begin
				if (ack_q) begin
					ack_q <= 1'b0;
					cnt_q <= 4'h0;
					tx_q <= rd_data;
					sda_oe <= phase_q == P_RDATA && !rd_data[7];
				end else if (cnt_q == 4'h8) begin
					ack_q <= 1'b1;
					sda_oe <= phase_q != P_RDATA;
					case (phase_q)
						P_ADDR: begin
							if (!addr_hit) begin
								phase_q <= P_IDLE;
								ack_q <= 1'b0;
								sda_oe <= 1'b0;
							end else if (shift_q[0]) begin
								phase_q <= P_RDATA;
							end else begin
								phase_q <= P_REG;
							end
						end
						P_REG: begin
							rd_addr <= shift_q;
							phase_q <= P_WDATA;
						end
						P_WDATA: begin
							wr <= '{1'b1, rd_addr, shift_q};
							rd_addr <= rd_addr + 8'h01;
						end
						default: begin
							rd_addr <= rd_addr + 8'h01;
						end
					endcase
				end else if (phase_q == P_RDATA && cnt_q != 4'h0) begin
					tx_q <= {tx_q[6:0], 1'b0};
					sda_oe <= !tx_q[6];
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/host_i2c_model.sv
// Host model: two-wire bus master for register access
`default_nettype none
module host_i2c_model #(
	parameter logic [6:0] ADDR = 7'h2c,
	parameter int HALF = 8
) (
	input wire logic ref_clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bus idle with both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One serial clock phase
	task automatic half();
		repeat (HALF) @(negedge ref_clk);
	endtask
	// Start or repeated start
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
	endtask
	// Data moves only well after the clock fall
	task automatic stop();
		repeat (2) @(negedge ref_clk);
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask
	task automatic put_bit(input logic b, output logic r);
		repeat (2) @(negedge ref_clk);
		sda_low = !b;
		half();
		scl = 1'b1;
		half();
		r = sda_wire;
		scl = 1'b0;
	endtask
	// Eight bits then the acknowledge slot, released by the host
	task automatic put_byte(input logic [7:0] d, output logic [7:0] q,
		output logic ack);
		logic nack;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], q[i]);
		end
		put_bit(1'b1, nack);
		ack = !nack;
	endtask
	// Host launch and cancel also pass through here
	task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		put_byte({ADDR, 1'b0}, q, a0);
		put_byte(p, q, a1);
		put_byte(d, q, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	// Host ends the read with a not-acknowledge
	task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
		output logic ok);
		logic a0, a1, a2, x;
		start();
		put_byte({ADDR, 1'b0}, d, a0);
		put_byte(p, d, a1);
		start();
		put_byte({ADDR, 1'b1}, d, a2);
		put_byte(8'hff, d, x);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule
`default_nettype wire

// >>> tb/haptic_front_end_monitor.sv
// Port checker for the haptic front end
`default_nettype none
module haptic_front_end_monitor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic trig_pin,
	input wire logic [7:0] analog_code,
	input wire logic [14:0] rom_addr,
	input wire haptic_pkg::rom_word_t rom_data,
	input wire logic signed [8:0] drive_level,
	input wire logic drive_active,
	input wire logic track_resonance,
	input wire logic drive_polarity,
	input wire logic [2:0] active_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Serial data pin behaviour
	a_sda_value_low: assert property (sda_out == 1'b0)
		else $error("data pin value not low");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line moved while clock high");
	a_oe_full_bit: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("data line pulse too short");
	// Drive outputs against mode and inputs
	a_idle_level_zero: assert property (
		!drive_active [*2] |-> drive_level == 9'sd0)
		else $error("level without active drive");
	a_analog_linear: assert property (
		(active_mode == haptic_pkg::MODE_ANALOG && drive_active &&
		$stable(analog_code)) [*4] |->
		drive_level == $signed({1'b0, analog_code}))
		else $error("analog level not mapped");
	a_realtime_positive: assert property (
		active_mode == haptic_pkg::MODE_REALTIME && drive_active |=>
		!drive_level[8])
		else $error("realtime level negative");
	a_track_pol_fixed: assert property (
		track_resonance [*2] |-> drive_polarity)
		else $error("polarity moved while tracking");
	a_level_mode_stop: assert property (
		(active_mode == haptic_pkg::MODE_LEVEL && !trig_pin) [*6] |->
		!drive_active)
		else $error("level trigger low but drive on");
	a_audio_silent: assert property (
		(active_mode == haptic_pkg::MODE_AUDIO) [*2] |-> drive_level == 9'sd0)
		else $error("audio mode drives");
	// Main scenarios reached
	c_analog_drive: cover property (
		active_mode == haptic_pkg::MODE_ANALOG && drive_active);
	c_library_play: cover property (drive_active && drive_level > 9'sd0 &&
		active_mode == haptic_pkg::MODE_MEM);
	c_polarity_turn: cover property ($changed(drive_polarity));
endmodule
bind haptic_front_end haptic_front_end_monitor i_mon (
	.ref_clk, .arst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .trig_pin,
	.analog_code, .rom_addr, .rom_data, .drive_level, .drive_active,
	.track_resonance, .drive_polarity, .active_mode
);
`default_nettype wire

// >>> tb/haptic_playback_front_end_tb_top.sv
// Self-checking bench for the haptic front end
`default_nettype none
module haptic_playback_front_end_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 600;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic trig_pin = 1'b0;
	logic pwm_on = 1'b0;
	logic [5:0] pwm_cnt = 6'h00;
	logic [7:0] analog_code = 8'h00;
	logic [14:0] rom_addr;
	logic signed [8:0] drive_level;
	logic drive_active, track_resonance, drive_polarity, ok;
	logic scl, sda_low, sda_oe, sda_wire;
	logic [2:0] active_mode;
	logic [7:0] rd;
	logic [24:0] rows [11];
	haptic_pkg::rom_word_t rom_data;
	int n_mismatch = 0;
	int compares = 0;
	always #2 ref_clk = ~ref_clk;
	// Pulled-up data line and a two-entry waveform for every identifier
	assign sda_wire = !(sda_low || sda_oe);
	assign rom_data = (rom_addr[4:0] == 5'h00) ? 18'h06402 : 18'h2ce01;
	// Half-duty PWM on the trigger pin, period 64 clocks
	always @(negedge ref_clk) begin
		if (pwm_on) begin
			pwm_cnt <= pwm_cnt + 6'h01;
			trig_pin <= pwm_cnt[5];
		end
	end
	haptic_front_end #(.MS_CYC(MS), .OL_HALF_CYC(20)) i_dut (
		.ref_clk, .arst_n, .scl_in(scl), .sda_in(sda_wire), .sda_out(),
		.sda_oe, .trig_pin, .analog_code, .rom_addr, .rom_data,
		.drive_level, .drive_active, .track_resonance, .drive_polarity,
		.active_mode
	);
	host_i2c_model i_host (.ref_clk, .sda_wire, .scl, .sda_low);
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		i_host.write_reg(p, d, ok);
		chk({15'h0, ok}, 16'h0001);
	endtask
	task automatic rdc(input logic [7:0] p, input logic [7:0] e);
		i_host.read_reg(p, rd, ok);
		chk({7'h0, ok, rd}, {8'h01, e});
	endtask
	// Bounded wait for the drive flag
	task automatic wait_act(input logic v, input int lim);
		int n = 0;
		while (drive_active !== v) begin
			@(negedge ref_clk);
			n++;
			if (n > lim) begin
				n_mismatch++;
				finish_test();
			end
		end
	endtask
	task automatic settle(input logic [8:0] e);
		repeat (8) @(negedge ref_clk);
		chk({7'h0, drive_level}, {7'h0, e});
	endtask
	// Length of one playback, allowing for the bus write tail
	task automatic play_len(input int e);
		int n = 0;
		wait_act(1'b1, 400);
		while (drive_active === 1'b1 && n < e + 64) begin
			@(negedge ref_clk);
			n++;
		end
		chk({15'h0, n > e - 64 && n < e + 16}, 16'h0001);
	endtask
	// Clocks between two polarity turns
	task automatic gap(input int e);
		int n = 0;
		logic p;
		p = drive_polarity;
		while (drive_polarity === p && n < 9000) begin
			@(negedge ref_clk);
			n++;
		end
		p = drive_polarity;
		n = 0;
		while (drive_polarity === p && n < e + 8) begin
			@(negedge ref_clk);
			n++;
		end
		chk({15'h0, n >= e - 2 && n <= e + 2}, 16'h0001);
	endtask
	task automatic pulse();
		trig_pin = 1'b1;
		repeat (8) @(negedge ref_clk);
		trig_pin = 1'b0;
	endtask
	initial begin
		rows = '{{8'h01, 1'b0, 8'h00, 8'h40}, {8'h17, 1'b0, 8'h00, 8'hff},
			{8'h0d, 1'b0, 8'h00, 8'h00}, {8'h10, 1'b0, 8'h00, 8'h00},
			{8'h04, 1'b0, 8'h00, 8'h00}, {8'h20, 1'b0, 8'h00, 8'h40},
			{8'h05, 1'b1, 8'h85, 8'h85}, {8'h0b, 1'b1, 8'h7f, 8'h7f},
			{8'h0e, 1'b1, 8'h80, 8'h80}, {8'h30, 1'b1, 8'h55, 8'h00},
			{8'h00, 1'b1, 8'hff, 8'h00}};
		repeat (10) @(negedge ref_clk);
		chk({5'h0, drive_active, drive_polarity, drive_level}, 16'h0200);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		// Reset values, read-back, unmapped and read-only places
		foreach (rows[i]) begin
			if (rows[i][16])
				wr(rows[i][24:17], rows[i][15:8]);
			rdc(rows[i][24:17], rows[i][7:0]);
		end
		// Wave, 10 ms wait slot, wave, zero slot; slots set first
		wr(8'h03, 8'h06);
		wr(8'h04, 8'h01);
		wr(8'h05, 8'h81);
		wr(8'h06, 8'h01);
		wr(8'h07, 8'h00);
		wr(8'h01, 8'h00);
		wr(8'h0c, 8'h01);
		chk({7'h0, drive_level}, 16'h0064);
		chk({13'h0, rom_addr[14:12]}, 16'h0006);
		play_len(40 * MS);
		rdc(8'h0c, 8'h00);
		// Fine step, overdrive stretched, brake shrunk to nothing
		wr(8'h1f, 8'h01);
		wr(8'h0d, 8'h02);
		wr(8'h10, 8'hff);
		wr(8'h05, 8'h00);
		wr(8'h0c, 8'h01);
		play_len(4 * MS);
		wr(8'h0c, 8'h01);
		wr(8'h0c, 8'h00);
		chk({15'h0, drive_active}, 16'h0000);
		// Edge trigger: falling edge ignored, second rise cancels
		wr(8'h01, 8'h01);
		pulse();
		wait_act(1'b1, 40);
		repeat (40) @(negedge ref_clk);
		chk({15'h0, drive_active}, 16'h0001);
		pulse();
		repeat (12) @(negedge ref_clk);
		chk({15'h0, drive_active}, 16'h0000);
		// Level trigger follows the pin
		wr(8'h01, 8'h02);
		trig_pin = 1'b1;
		wait_act(1'b1, 40);
		trig_pin = 1'b0;
		repeat (12) @(negedge ref_clk);
		chk({15'h0, drive_active}, 16'h0000);
		// Analog, then resonant open loop at the programmed period
		wr(8'h01, 8'h04);
		analog_code = 8'h80;
		settle(9'h080);
		analog_code = 8'hff;
		settle(9'h0ff);
		wr(8'h1a, 8'h80);
		wr(8'h1d, 8'h01);
		wr(8'h20, 8'h05);
		gap(5 * 20);
		chk({15'h0, track_resonance}, 16'h0000);
		// Realtime amplitude, standby, audio
		wr(8'h02, 8'h33);
		wr(8'h01, 8'h05);
		settle(9'h033);
		wr(8'h01, 8'h45);
		chk({6'h0, drive_active, drive_level}, 16'h0000);
		wr(8'h01, 8'h06);
		settle(9'h000);
		chk({13'h0, active_mode}, 16'h0006);
		// PWM on a rotating mass, then resonant open loop
		wr(8'h1a, 8'h00);
		wr(8'h17, 8'h80);
		wr(8'h01, 8'h03);
		pwm_on = 1'b1;
		repeat (9000) @(negedge ref_clk);
		settle(9'h040);
		wr(8'h1a, 8'h80);
		gap(4096);
		settle(9'h080);
		pwm_on = 1'b0;
		finish_test();
	end
endmodule
`default_nettype wire
